// [hw/lcd_frame_div.sv]
// Frame rate divider of the working clock
`include "lcd_init_params.svh"
module lcd_frame_div
  import lcd_init_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  lcd_frame_if.src frame
);
  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } div_state_t;
  div_state_t st, next_st;
  localparam logic [11:0] DIV_LAST = 12'(`FRAME_DIV - 1);

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == DIV_LAST) begin // [RL11]
      next_st.cnt = 12'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 12'h001;
    end
  end

  // Bus activity never touches this counter [RL19]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign frame.tick = st.tick;
endmodule : lcd_frame_div

// [hw/lcd_frame_if.sv]
// Frame tick carrier between the top and the frame divider
interface lcd_frame_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : lcd_frame_if

// [hw/lcd_init_params.svh]
// Constants for the character LCD reset and initialisation block
`ifndef LCD_INIT_PARAMS_SVH
`define LCD_INIT_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define CLEAR_CYCLES 165
`define BUSY_TIME_US 2000
`define BUSY_CYCLES ((`BUSY_TIME_US * 1000) / `CLK_PERIOD_NS)
`define FRAME_DIV 3072
`define RST_ADVANCE_DIR 1'b1
`define RST_PAN_ON_WRITE 1'b0
`define RST_BUS_WIDTH 1'b1
`define RST_MUX_RATIO 1'b0
`define RST_BOOST_STAGE 2'h2
`define RST_DRIVE_LEVEL 6'h00
// Register map for the plain register port
`define REG_STATUS 4'h0
`define REG_ENTRY 4'h1
`define REG_DISPLAY 4'h2
`define REG_FUNC 4'h3
`define REG_ICON 4'h4
`define REG_CONF 4'h5
`define REG_DRIVE_A 4'h6
`define REG_DRIVE_B 4'h7
`define REG_BOOST 4'h8
`define REG_FRAMES 4'h9
`endif

// [hw/lcd_init_pkg.sv]
// Types for the character LCD reset and initialisation block
package lcd_init_pkg;
  typedef enum logic [1:0] {ST_RESET, ST_CLEAR, ST_WAIT, ST_READY} init_state_t;
endpackage : lcd_init_pkg

// [hw/lcd_init_top.sv]
// Reset, initialisation, host pins and register port of the LCD controller
//
// Function
// [RL1] External reset input is active high; high means reset.
// [RL2] Host holds reset high for at least three clock periods.
// [RL3] After reset, run 165-cycle screen clear and reset serial interface.
// [RL4] Busy flag reads one from reset until 2 ms initialisation ends.
// [RL5] Reset selects increment advance and no panning on write.
// [RL6] Reset clears display-on, cursor-visible and cursor-flash bits.
// [RL7] Reset selects 8-bit bus, one line, 1:18 mux, normal page.
// [RL8] Reset points the address pointer into the character buffer.
// [RL9] Reset selects character mode, no icon blink, config bits zero.
// [RL10] Reset zeroes drive levels; boost stage bits select three stages.
// [RL11] Frame rate is the working clock divided by 3072.
// [RL12] Clock may stop only during power-down.
// [RL13] Host holds power-down select low for normal operation.
// [RL14] Read/write high reads, low writes; undriven input reads high.
// [RL15] Busy flag may be shown on the top data line.
// [RL16] 4-bit mode uses only upper four data lines.
// [RL17] Data line 3 doubles as serial address least significant strap.
// [RL18] Host keeps parallel strobe low while the serial bus is used.
// [RL19] Timing and display run undisturbed by host bus transfers.
// [RL20] Host raises strobe; device latches or drives data at its fall.
// [RL21] Host waits for busy flag zero before issuing transfers.
`include "lcd_init_params.svh"
module lcd_init_top
  import lcd_init_pkg::*;
#(
  parameter int BUSY_CYCLES = `BUSY_CYCLES
)(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic powerdown_select_i,
  input wire logic strobe_i,
  input wire logic read_not_write_i,
  input wire logic instr_data_select_i,
  input wire logic [7:0] data_line_i,
  output logic [7:0] data_line_o,
  output logic [7:0] data_line_oe_o,
  output logic addr_lsb_strap_o,
  output logic serial_if_rst_o,
  output logic clearing_o,
  output logic busy_flag_o,
  output logic powerdown_o,
  output logic frame_tick_o,
  output logic [7:0] host_wr_data_o,
  output logic host_wr_instr_o,
  output logic host_wr_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);
  typedef struct packed {
    init_state_t state;
    logic [21:0] cnt;
    logic busy;
    logic clearing;
    logic serial_rst;
    logic strap_done;
    logic addr_strap;
    // Pin synchronisers, first stage read only by the second
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic strobe_d;
    logic nibble_hi;
    logic [3:0] nibble;
    logic advance_dir;
    logic pan_on_write;
    logic display_on;
    logic cursor_visible;
    logic cursor_flash;
    logic bus_width_bit;
    logic two_line;
    logic mux_ratio_bit;
    logic ext_page;
    logic icon_only_bit;
    logic icon_flash_bit;
    logic [3:0] conf_bits;
    logic ptr_in_symbols;
    logic [5:0] drive_a;
    logic [5:0] drive_b;
    logic [1:0] boost_stage_cfg;
    logic [7:0] frames;
    logic frame_tick;
    logic [7:0] dout;
    logic [7:0] doe;
    logic [7:0] wdata;
    logic wr_instr;
    logic wr;
    logic [7:0] rdata;
  } top_state_t;

  top_state_t st, next_st;
  lcd_frame_if frame_bus ();
  localparam logic [21:0] BUSY_LAST = 22'(BUSY_CYCLES - 1);
  localparam logic [21:0] CLEAR_LAST = 22'(`CLEAR_CYCLES - 1);

  lcd_frame_div u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .frame(frame_bus)
  );

  logic pd_s, e_s, rw_s, rs_s;
  logic [7:0] db_s;
  logic e_fall, rd_cycle, wr_cycle;

  always_comb begin
    pd_s = st.pin_s2[11];
    e_s = st.pin_s2[10];
    rw_s = st.pin_s2[9];
    rs_s = st.pin_s2[8];
    db_s = st.pin_s2[7:0];
    e_fall = st.strobe_d && !e_s; // [RL20]
    rd_cycle = e_fall && rw_s; // [RL14]
    wr_cycle = e_fall && !rw_s; // [RL14]
  end

  always_comb begin
    next_st = st;
    next_st.pin_s1 = {powerdown_select_i, strobe_i, read_not_write_i,
                      instr_data_select_i, data_line_i};
    next_st.pin_s2 = st.pin_s1;
    next_st.strobe_d = e_s;
    next_st.wr = 1'b0;
    next_st.serial_rst = 1'b0;
    next_st.frame_tick = frame_bus.tick;
    if (frame_bus.tick) begin
      next_st.frames = st.frames + 8'h01;
    end
    // Strap caught once, after reset release, from the synchronised line
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.addr_strap = db_s[3]; // [RL17]
    end
    case (st.state)
      ST_RESET: begin
        next_st.state = ST_CLEAR;
        next_st.serial_rst = 1'b1; // [RL3]
        next_st.clearing = 1'b1;
        next_st.cnt = 22'h000000;
      end
      ST_CLEAR: begin
        next_st.cnt = st.cnt + 22'h000001;
        if (st.cnt == CLEAR_LAST) begin // [RL3]
          // Busy wait counts from zero, not on from the clear count
          next_st.cnt = 22'h000000;
          next_st.clearing = 1'b0;
          next_st.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_st.cnt = st.cnt + 22'h000001;
        if (st.cnt == BUSY_LAST) begin // [RL4]
          next_st.busy = 1'b0;
          next_st.state = ST_READY;
        end
      end
      ST_READY: begin
      end
      default: begin
        next_st.state = ST_RESET;
      end
    endcase
    // Bus turnaround: let go of the lines as soon as a new strobe rises
    if (e_s && !st.strobe_d) begin // [RL20]
      next_st.doe = 8'h00;
    end
    // Instruction read: drive on strobe fall; busy on the top line [RL15]
    if (rd_cycle && !rs_s) begin
      next_st.doe = st.bus_width_bit ? 8'hff : 8'hf0; // [RL16]
      next_st.dout = {st.busy, 7'h00};
    end else if (wr_cycle) begin
      next_st.doe = 8'h00;
      if (st.bus_width_bit) begin
        next_st.wdata = db_s;
        next_st.wr_instr = !rs_s;
        next_st.wr = 1'b1;
      end else if (!st.nibble_hi) begin
        next_st.nibble = db_s[7:4]; // [RL16]
        next_st.nibble_hi = 1'b1;
      end else begin
        next_st.wdata = {st.nibble, db_s[7:4]};
        next_st.wr_instr = !rs_s;
        next_st.wr = 1'b1;
        next_st.nibble_hi = 1'b0;
      end
    end else if (rd_cycle) begin
      next_st.doe = st.bus_width_bit ? 8'hff : 8'hf0;
      next_st.dout = 8'h00;
    end
    // Register port, one-cycle read latency
    if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_ENTRY: {next_st.advance_dir, next_st.pan_on_write} = reg_wdata_i[1:0];
        `REG_DISPLAY: {next_st.display_on, next_st.cursor_visible,
                       next_st.cursor_flash} = reg_wdata_i[2:0];
        `REG_FUNC: {next_st.bus_width_bit, next_st.two_line,
                    next_st.mux_ratio_bit, next_st.ext_page} = reg_wdata_i[3:0];
        `REG_ICON: {next_st.ptr_in_symbols, next_st.icon_only_bit,
                    next_st.icon_flash_bit} = reg_wdata_i[2:0];
        `REG_CONF: next_st.conf_bits = reg_wdata_i[3:0];
        `REG_DRIVE_A: next_st.drive_a = reg_wdata_i[5:0];
        `REG_DRIVE_B: next_st.drive_b = reg_wdata_i[5:0];
        `REG_BOOST: next_st.boost_stage_cfg = reg_wdata_i[1:0];
        default: begin
        end
      endcase
    end
    next_st.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_STATUS: next_st.rdata = {3'h0, pd_s, st.addr_strap, st.nibble_hi,
                                      st.clearing, st.busy};
        `REG_ENTRY: next_st.rdata = {6'h00, st.advance_dir, st.pan_on_write};
        `REG_DISPLAY: next_st.rdata = {5'h00, st.display_on, st.cursor_visible,
                                       st.cursor_flash};
        `REG_FUNC: next_st.rdata = {4'h0, st.bus_width_bit, st.two_line,
                                    st.mux_ratio_bit, st.ext_page};
        `REG_ICON: next_st.rdata = {5'h00, st.ptr_in_symbols, st.icon_only_bit,
                                    st.icon_flash_bit};
        `REG_CONF: next_st.rdata = {4'h0, st.conf_bits};
        `REG_DRIVE_A: next_st.rdata = {2'h0, st.drive_a};
        `REG_DRIVE_B: next_st.rdata = {2'h0, st.drive_b};
        `REG_BOOST: next_st.rdata = {6'h00, st.boost_stage_cfg};
        `REG_FRAMES: next_st.rdata = st.frames;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // Reset is synchronous; host keeps it for at least three edges [RL1] [RL2]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.state <= ST_RESET;
      st.busy <= 1'b1; // [RL4]
      st.advance_dir <= `RST_ADVANCE_DIR; // [RL5]
      st.pan_on_write <= `RST_PAN_ON_WRITE; // [RL5]
      st.display_on <= 1'b0; // [RL6]
      st.bus_width_bit <= `RST_BUS_WIDTH; // [RL7]
      st.mux_ratio_bit <= `RST_MUX_RATIO; // [RL7]
      st.ptr_in_symbols <= 1'b0; // [RL8]
      st.icon_only_bit <= 1'b0; // [RL9]
      st.drive_a <= `RST_DRIVE_LEVEL; // [RL10]
      st.drive_b <= `RST_DRIVE_LEVEL; // [RL10]
      st.boost_stage_cfg <= `RST_BOOST_STAGE; // [RL10]
      // Pins keep being sampled so the strap sees the real level at release
      st.pin_s1 <= next_st.pin_s1;
      st.pin_s2 <= st.pin_s1;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    data_line_o = st.dout;
    data_line_oe_o = st.doe;
    addr_lsb_strap_o = st.addr_strap;
    serial_if_rst_o = st.serial_rst;
    clearing_o = st.clearing;
    busy_flag_o = st.busy;
    powerdown_o = st.pin_s2[11];
    frame_tick_o = st.frame_tick;
    host_wr_data_o = st.wdata;
    host_wr_instr_o = st.wr_instr;
    host_wr_o = st.wr;
    reg_rdata_o = st.rdata;
  end
endmodule : lcd_init_top

// [verification/lcd_host_model.sv]
// Host microcontroller model on the parallel pins
module lcd_host_model (
  input wire logic clk_i,
  input wire logic [7:0] dout_i,
  input wire logic [7:0] oe_i,
  output logic strobe_o = 1'b0,
  output logic rnw_o,
  output logic rs_o = 1'b0,
  output logic [7:0] line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv = 8'h00;
  logic [7:0] hval = 8'h00;
  logic rnw_drv = 1'b0;
  logic rnw_val = 1'b0;
  // Released lines float up through the pull-ups
  assign rnw_o = rnw_drv ? rnw_val : 1'b1;
  assign line_o = (oe_i & dout_i) | (~oe_i & drv & hval) | (~oe_i & ~drv);
  task automatic xfer(input logic sel, input logic rd, input logic [7:0] d,
                      input logic [7:0] en, output logic [7:0] got);
    @(posedge clk_i);
    rs_o <= sel;
    rnw_drv <= 1'b1;
    rnw_val <= rd;
    hval <= d;
    drv <= rd ? 8'h00 : en;
    @(posedge clk_i);
    strobe_o <= 1'b1;
    // Long enough for the device to release the lines before the fall
    repeat (4) @(posedge clk_i);
    strobe_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    got = line_o;
    drv <= 8'h00;
    rnw_drv <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : xfer
endmodule : lcd_host_model

// [verification/lcd_init_props.sv]
// Checker for the LCD reset and initialisation block
module lcd_init_props #(
  parameter int BUSY_CYCLES = 200000
)(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clearing_o,
  input wire logic serial_if_rst_o,
  input wire logic busy_flag_o,
  input wire logic frame_tick_o,
  input wire logic [7:0] data_line_oe_o,
  input wire logic host_wr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int clr_cnt = 0;
  int busy_cnt = 0;
  int fr_cnt = 0;
  logic fr_seen = 1'b0;
  // ==========================================
  // Cycle counters
  always_ff @(posedge clk_i) begin
    clr_cnt <= clearing_o ? clr_cnt + 1 : 0;
    busy_cnt <= (busy_flag_o && !clearing_o && !sys_rst_i) ? busy_cnt + 1 : 0;
    fr_cnt <= frame_tick_o ? 1 : fr_cnt + 1;
    // First tick after reset has no reference
    fr_seen <= !sys_rst_i && (fr_seen || frame_tick_o);
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ==========================================
  // Properties
  a_reset_state: assert property (disable iff (1'b0) sys_rst_i |=> busy_flag_o &&
    !clearing_o && !frame_tick_o && data_line_oe_o == 8'h00 && !host_wr_o)
    else $error("outputs wrong in reset");
  a_clear_start: assert property ($fell(sys_rst_i) |=> clearing_o && serial_if_rst_o)
    else $error("clear did not start");
  a_clear_len: assert property ($fell(clearing_o) |-> clr_cnt == 165)
    else $error("clear length wrong");
  a_serial_pulse: assert property (serial_if_rst_o |=> !serial_if_rst_o)
    else $error("serial reset not a pulse");
  a_busy_clear: assert property (clearing_o |-> busy_flag_o)
    else $error("busy low during clear");
  a_busy_len: assert property ($fell(busy_flag_o) |->
    busy_cnt inside {[BUSY_CYCLES - 1:BUSY_CYCLES + 2]})
    else $error("busy length wrong");
  a_busy_stays: assert property (!busy_flag_o |=> !busy_flag_o)
    else $error("busy rose without reset");
  a_frame_period: assert property (frame_tick_o && fr_seen |-> fr_cnt == 3072)
    else $error("frame period wrong");
  a_tick_pulse: assert property (frame_tick_o |=> !frame_tick_o)
    else $error("frame tick too long");
endmodule : lcd_init_props

// [verification/tb.sv]
// Self-checking bench for the LCD reset and initialisation block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 50;
  localparam logic [7:0] DFLT [9] = '{8'h0b, 8'h02, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'h02};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic powerdown_select_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic strobe, rnw, rs, strap, srst, clearing, busy, pd_o, tick, winstr, wr, lastins;
  logic [7:0] line, dout, oe, wdata, rdata, lastwr, q;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rel = 0;
  lcd_init_top #(.BUSY_CYCLES(BC)) DUT (.clk_i, .sys_rst_i, .powerdown_select_i,
    .strobe_i(strobe), .read_not_write_i(rnw), .instr_data_select_i(rs), .data_line_i(line),
    .data_line_o(dout), .data_line_oe_o(oe), .addr_lsb_strap_o(strap),
    .serial_if_rst_o(srst), .clearing_o(clearing), .busy_flag_o(busy), .powerdown_o(pd_o),
    .frame_tick_o(tick), .host_wr_data_o(wdata), .host_wr_instr_o(winstr), .host_wr_o(wr),
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata));
  lcd_host_model host (.clk_i, .dout_i(dout), .oe_i(oe), .strobe_o(strobe), .rnw_o(rnw),
    .rs_o(rs), .line_o(line));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wr === 1'b1) begin
      lastwr <= wdata;
      lastins <= winstr;
    end
    // Whole run needs under 8000 cycles
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : rw
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(rdata, e);
  endtask : rchk
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  // ==========================================
  // Scenarios
  task automatic t_defaults;
    for (int i = 0; i < 9; i++) rchk(i[3:0], DFLT[i]);
    rchk(4'hc, 8'h00);
    host.xfer(1'b0, 1'b1, 8'h00, 8'hff, q);
    chk(q, 8'h80);
  endtask : t_defaults
  task automatic t_busy;
    while (busy !== 1'b0 && cyc < rel + 1000) @(negedge clk_i);
    chk({7'h00, (cyc - rel) inside {[165 + BC:171 + BC]}}, 8'h01);
    rchk(4'h0, 8'h08);
  endtask : t_busy
  task automatic t_regs;
    rw(4'h0, 8'hff);
    rw(4'h6, 8'hff);
    rw(4'hd, 8'h55);
    rchk(4'h0, 8'h08);
    rchk(4'h6, 8'h3f);
    rchk(4'hd, 8'h00);
  endtask : t_regs
  task automatic t_write8;
    host.xfer(1'b1, 1'b0, 8'ha5, 8'hff, q);
    chk(lastwr, 8'ha5);
    chk({7'h00, lastins}, 8'h00);
    host.xfer(1'b0, 1'b0, 8'h80, 8'hff, q);
    chk({lastins, lastwr[6:0]}, 8'h80);
  endtask : t_write8
  task automatic t_nibble;
    rw(4'h3, 8'h00);
    host.xfer(1'b1, 1'b0, 8'h70, 8'hf0, q);
    rchk(4'h0, 8'h0c);
    host.xfer(1'b1, 1'b0, 8'hc0, 8'hf0, q);
    chk(lastwr, 8'h7c);
    host.xfer(1'b0, 1'b1, 8'h00, 8'h00, q);
    chk(q, 8'h0f);
    chk(oe, 8'hf0);
    host.xfer(1'b0, 1'b1, 8'h00, 8'h00, q);
    rw(4'h3, 8'h08);
  endtask : t_nibble
  task automatic t_pd;
    @(posedge clk_i);
    powerdown_select_i <= 1'b1;
    // Two synchroniser stages before the pin shows
    repeat (2) @(posedge clk_i);
    rchk(4'h0, 8'h18);
    chk({7'h00, pd_o}, 8'h01);
    @(posedge clk_i);
    powerdown_select_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk({7'h00, pd_o}, 8'h00);
  endtask : t_pd
  task automatic t_frame;
    int n;
    while (tick !== 1'b1) @(negedge clk_i);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (tick !== 1'b1);
    chk({7'h00, n == 3072}, 8'h01);
  endtask : t_frame
  task automatic t_strap;
    @(posedge clk_i);
    host.drv <= 8'h08;
    host.hval <= 8'h00;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rchk(4'h0, 8'h03);
    @(posedge clk_i);
    host.drv <= 8'h00;
    rchk(4'h6, 8'h00);
  endtask : t_strap
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rel = cyc;
    t_defaults();
    t_busy();
    t_regs();
    t_write8();
    t_nibble();
    t_pd();
    t_frame();
    t_strap();
    final_report();
  end
endmodule : tb
bind lcd_init_top lcd_init_props #(.BUSY_CYCLES(BUSY_CYCLES)) props (.clk_i, .sys_rst_i,
  .clearing_o, .serial_if_rst_o, .busy_flag_o, .frame_tick_o, .data_line_oe_o, .host_wr_o);
